// ==== src/host_cpu_bus_slave_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module host_cpu_bus_slave_port #(
  parameter int DATA_W = `HP_DATA_W,
  parameter int ADDR_W = `HP_ADDR_W
) (
  // Host bus clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Host address and strobes.
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic chip_select_n,
  input wire logic address_latch_strobe,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic dma_write_ack_n,
  input wire logic dma_read_ack_n,
  // Host data bus split into its three parts.
  input wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  // Transfer acknowledge pin.
  output logic transfer_ack_n,
  output logic transfer_ack_oe,
  // DMA requests and interrupts toward the host.
  output logic dma_write_request_n,
  output logic dma_write_request_oe,
  output logic dma_read_request_n,
  output logic dma_read_request_oe,
  output logic interrupt_request_first_n,
  output logic interrupt_request_first_oe,
  output logic interrupt_request_second_n,
  output logic interrupt_request_second_oe,
  // Core side of an access.
  output logic [ADDR_W-1:0] core_address,
  output host_port_pkg::access_kind_t core_kind,
  output logic core_read,
  output logic core_write,
  output logic [DATA_W-1:0] core_write_data,
  input wire logic [DATA_W-1:0] core_read_data,
  input wire logic core_ready,
  // Core side of DMA and interrupt requests.
  input wire logic core_dma_write_req,
  input wire logic core_dma_read_req,
  input wire logic core_irq_first,
  input wire logic core_irq_second
);

  host_port_pkg::port_state_t state;
  host_port_pkg::port_state_t next_state;
  logic [ADDR_W-1:0] next_core_address;
  host_port_pkg::access_kind_t next_core_kind;
  logic next_core_read;
  logic next_core_write;
  logic [DATA_W-1:0] next_core_write_data;
  logic [DATA_W-1:0] next_host_data_out;
  logic next_transfer_ack_n;
  logic is_write;
  logic next_is_write;
  logic next_transfer_ack_oe;
  logic [`HP_SIDEBAND_W-1:0] side_req;
  logic [`HP_SIDEBAND_W-1:0] side_pin_n;
  logic [`HP_SIDEBAND_W-1:0] side_pin_oe;

  // The pin widths are fixed by the host bus, so other values are refused.
  if (DATA_W != `HP_DATA_W) begin : g_bad_data_w
    $error("host data bus must be 32 bits");
  end
  if (ADDR_W != `HP_ADDR_W) begin : g_bad_addr_w
    $error("host word address must be 22 bits");
  end

  // The data pins are enabled straight from the host strobes, not from a
  // flop, so a read turns the bus around without a clock of latency.
  always_comb begin
    host_data_oe = ~rst & ~chip_select_n & ~read_enable_n;
  end

  // Access sequencer on the host bus clock; the host bus is synchronous
  // to this clock, so its pins are sampled without a synchroniser.
  always_comb begin
    next_state = state;
    next_core_address = core_address;
    next_core_kind = core_kind;
    next_core_read = 1'b0;
    next_core_write = 1'b0;
    next_core_write_data = core_write_data;
    next_host_data_out = host_data_out;
    next_transfer_ack_n = 1'b1;
    next_is_write = is_write;
    unique case (state)
      host_port_pkg::port_idle: begin
        // A strobe without chip select belongs to another device.
        if (address_latch_strobe && !chip_select_n) begin
          next_core_address = word_address;
          next_state = host_port_pkg::port_access;
        end
      end
      host_port_pkg::port_access: begin
        // Enables arrive one cycle after the strobe; wait states last as
        // long as the core is not ready, and the host keeps its strobes.
        // Dropping chip select here abandons the access without acknowledge.
        // Should both enables be low at once, the read takes priority.
        if (chip_select_n) begin
          next_state = host_port_pkg::port_idle;
        end else if (!read_enable_n) begin
          next_is_write = 1'b0;
          // The kind follows the acknowledge pin as the enable is seen.
          next_core_kind = dma_read_ack_n ? host_port_pkg::kind_register
                                          : host_port_pkg::kind_dma_read;
          // Read data is taken from the core together with the acknowledge,
          // so the word stands on the bus through the acknowledge cycle.
          if (core_ready) begin
            next_core_read = 1'b1;
            next_host_data_out = core_read_data;
            next_transfer_ack_n = 1'b0;
            next_state = host_port_pkg::port_ack;
          end
        end else if (!write_enable_n) begin
          next_is_write = 1'b1;
          // A write needs only the core's readiness, not its data.
          next_core_kind = dma_write_ack_n ? host_port_pkg::kind_register
                                           : host_port_pkg::kind_dma_write;
          if (core_ready) begin
            next_transfer_ack_n = 1'b0;
            next_state = host_port_pkg::port_ack;
          end
        end
      end
      host_port_pkg::port_ack: begin
        // The write word is taken on the edge that ends the acknowledge.
        if (is_write) begin
          next_core_write = 1'b1;
          next_core_write_data = host_data_in;
        end
        next_state = host_port_pkg::port_hold;
      end
      host_port_pkg::port_hold: begin
        // Chip select must be seen high before the next strobe is taken,
        // which leaves at least one idle cycle between accesses.
        if (chip_select_n) begin
          next_state = host_port_pkg::port_idle;
        end
      end
    endcase
  end

  // Of these flops, host_data_out and transfer_ack_n feed the host pins directly, with no logic after them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= host_port_pkg::port_idle;
      core_address <= `HP_ADDR_RESET;
      core_kind <= host_port_pkg::kind_register;
      core_read <= 1'b0;
      core_write <= 1'b0;
      core_write_data <= `HP_DATA_RESET;
      host_data_out <= `HP_DATA_RESET;
      transfer_ack_n <= 1'b1;
      is_write <= 1'b0;
    end else begin
      state <= next_state;
      core_address <= next_core_address;
      core_kind <= next_core_kind;
      core_read <= next_core_read;
      core_write <= next_core_write;
      core_write_data <= next_core_write_data;
      host_data_out <= next_host_data_out;
      transfer_ack_n <= next_transfer_ack_n;
      is_write <= next_is_write;
    end
  end

  // The acknowledge enable lives on the falling edge so that it is driven
  // half a cycle before any rising edge can assert it, and released half a
  // cycle after the host lets go of chip select.
  always_comb begin
    next_transfer_ack_oe = ~chip_select_n;
  end

  // The enable follows chip select even when no strobe starts an access.
  always_ff @(negedge mclk or posedge rst) begin
    if (rst) begin
      transfer_ack_oe <= 1'b0;
    end else begin
      transfer_ack_oe <= next_transfer_ack_oe;
    end
  end

  // Core requests come from logic on this clock and need no synchroniser.
  always_comb begin
    side_req[0] = core_dma_write_req;
    side_req[1] = core_dma_read_req;
    side_req[2] = core_irq_first;
    side_req[3] = core_irq_second;
  end

  // One shared driver keeps the four sideband pins alike in reset.
  sideband_drivers #(
    .WIDTH(`HP_SIDEBAND_W)
  ) u_sideband (
    .mclk(mclk),
    .rst(rst),
    .assert_req(side_req),
    .pin_n(side_pin_n),
    .pin_oe(side_pin_oe)
  );

  // The sideband lines leave the driver flops without further logic.
  always_comb begin
    dma_write_request_n = side_pin_n[0];
    dma_write_request_oe = side_pin_oe[0];
    dma_read_request_n = side_pin_n[1];
    dma_read_request_oe = side_pin_oe[1];
    interrupt_request_first_n = side_pin_n[2];
    interrupt_request_first_oe = side_pin_oe[2];
    interrupt_request_second_n = side_pin_n[3];
    interrupt_request_second_oe = side_pin_oe[3];
  end

endmodule

`default_nettype wire

// ==== src/host_port_cfg.svh ====
// Overview of operation
// - Reset holds every host port output tri-stated.
// - Data bus 32 bits, rising edge both ways.
// - Data driven only while select and read enable.
// - One host bus clock times all signals.
// - Acknowledge driven from falling edge after select.
// - Read acknowledge once valid data is driven.
// - Write acknowledge when ready, capture next edge.
// - Acknowledge tri-stated falling edge after deselect.
// - DMA write request output, active low.
// - DMA read request when packet data ready.
// - Two active-low interrupt request outputs.
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

`define HP_DATA_W 32
`define HP_ADDR_W 22
`define HP_ADDR_LSB 2
`define HP_CLK_PERIOD_NS 25
`define HP_DATA_RESET 32'h0000_0000
`define HP_ADDR_RESET 22'h00_0000
`define HP_SIDEBAND_W 4
`define HP_SIDEBAND_RESET 4'hf

`endif

// ==== src/host_port_pkg.sv ====
package host_port_pkg;

  typedef enum logic [1:0] {
    port_idle = 2'b00,
    port_access = 2'b01,
    port_ack = 2'b11,
    port_hold = 2'b10
  } port_state_t;

  typedef enum logic [1:0] {
    kind_register = 2'b00,
    kind_dma_write = 2'b01,
    kind_dma_read = 2'b10
  } access_kind_t;

endpackage

// ==== src/sideband_drivers.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "host_port_cfg.svh"

module sideband_drivers #(
  parameter int WIDTH = `HP_SIDEBAND_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Active-high requests from the core.
  input wire logic [WIDTH-1:0] assert_req,
  // Active-low pins and their enables.
  output logic [WIDTH-1:0] pin_n,
  output logic [WIDTH-1:0] pin_oe
);

  logic [WIDTH-1:0] next_pin_n;
  logic [WIDTH-1:0] next_pin_oe;

  if (WIDTH < 1) begin : g_bad_width
    $error("sideband width must be at least one");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      always_comb begin
        next_pin_n[i] = ~assert_req[i];
        next_pin_oe[i] = 1'b1;
      end

      // Pins float in reset and start driving on the first edge after it.
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pin_n[i] <= 1'b1;
          pin_oe[i] <= 1'b0;
        end else begin
          pin_n[i] <= next_pin_n[i];
          pin_oe[i] <= next_pin_oe[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== dv/host_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_port_asserts #(
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Host side.
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic [DATA_W-1:0] host_data_in,
  input wire logic host_data_oe,
  input wire logic transfer_ack_n,
  input wire logic transfer_ack_oe,
  input wire logic dma_write_request_n,
  input wire logic dma_read_request_n,
  // Core side.
  input wire logic core_read,
  input wire logic core_write,
  input wire logic [DATA_W-1:0] core_write_data,
  input wire logic core_dma_write_req,
  input wire logic core_dma_read_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rst_quiet_a: assert property (disable iff (1'b0)
    rst |-> !host_data_oe && !transfer_ack_oe) else $error("driven in reset");
  data_oe_a: assert property (
    host_data_oe == (!chip_select_n && !read_enable_n)) else $error("data oe");
  ack_tristate_a: assert property (
    @(negedge mclk) transfer_ack_oe == !$past(chip_select_n))
    else $error("ack enable wrong");
  ack_pulse_a: assert property (
    !transfer_ack_n |-> transfer_ack_oe ##1 transfer_ack_n) else $error("ack");
  read_ack_a: assert property (
    !transfer_ack_n && !read_enable_n |-> host_data_oe && core_read)
    else $error("read ack without data");
  write_cap_a: assert property (!transfer_ack_n && !write_enable_n |=>
    core_write && core_write_data == $past(host_data_in)) else $error("wr");
  dma_wr_req_a: assert property (!$past(rst) |->
    dma_write_request_n == !$past(core_dma_write_req)) else $error("dreq w");
  dma_rd_req_a: assert property (!$past(rst) |->
    dma_read_request_n == !$past(core_dma_read_req)) else $error("dreq r");
  cover property (!transfer_ack_n && !read_enable_n);
  cover property (!transfer_ack_n && !write_enable_n);
  cover property (!dma_read_request_n);
endmodule
bind host_cpu_bus_slave_port host_port_asserts #(.DATA_W(DATA_W)) chk (.*);
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock.
  input wire logic mclk,
  // Host requests.
  output var logic [21:0] word_address,
  output var logic chip_select_n,
  output var logic address_latch_strobe,
  output var logic write_enable_n,
  output var logic read_enable_n,
  output var logic dma_write_ack_n,
  output var logic dma_read_ack_n,
  // Data wire and acknowledge.
  output logic [31:0] host_data_in,
  input wire logic [31:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic transfer_ack_n
);
  logic [31:0] drv = 32'h0;
  int waits;
  // A released bus shows inverted data so stale values never pass as reads.
  assign host_data_in = host_data_oe ? host_data_out : drv;
  initial begin
    {chip_select_n, write_enable_n, read_enable_n} = 3'h7;
    {dma_write_ack_n, dma_read_ack_n, address_latch_strobe} = 3'h6;
    word_address = 22'h0;
  end
  task automatic xfer(input logic wr, input logic [1:0] dk,
                      input logic [21:0] a, inout logic [31:0] d);
    @(posedge mclk);
    word_address <= a;
    {chip_select_n, address_latch_strobe} <= 2'h1;
    @(posedge mclk);
    address_latch_strobe <= 1'b0;
    {write_enable_n, read_enable_n} <= {!wr, wr};
    // The kind code sets the write acknowledge on 1 and the read one on 2.
    {dma_write_ack_n, dma_read_ack_n} <= {!dk[0], !dk[1]};
    if (wr) drv <= d;
    waits = 0;
    // Acknowledge and read data are taken at the edge that samples them.
    do @(posedge mclk);
    while (transfer_ack_n !== 1'b0 && waits++ < 50);
    if (!wr) d = host_data_in;
    {chip_select_n, write_enable_n, read_enable_n} <= 3'h7;
    {dma_write_ack_n, dma_read_ack_n} <= 2'h3;
    drv <= ~drv;
    @(posedge mclk);
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ==== dv/test_host_cpu_bus_slave_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module test_host_cpu_bus_slave_port;
  int bad_count = 0;
  int checks_done = 0;
  logic mclk = 1'b0;
  logic rst = 1'b0;
  logic core_ready = 1'b1;
  logic core_dma_write_req = 1'b0, core_dma_read_req = 1'b0;
  logic core_irq_first = 1'b0, core_irq_second = 1'b0;
  logic [31:0] core_read_data = 32'h0, host_data_in, host_data_out;
  logic [31:0] core_write_data, wdat;
  logic [21:0] word_address, core_address, wadr;
  logic [1:0] wknd;
  logic chip_select_n, address_latch_strobe, write_enable_n, read_enable_n;
  logic dma_write_ack_n, dma_read_ack_n, host_data_oe, transfer_ack_n;
  logic transfer_ack_oe, core_read, core_write, dma_write_request_n;
  logic dma_write_request_oe, dma_read_request_n, dma_read_request_oe;
  logic interrupt_request_first_n, interrupt_request_first_oe;
  logic interrupt_request_second_n, interrupt_request_second_oe;
  host_port_pkg::access_kind_t core_kind;
  wire logic [3:0] side_n = {interrupt_request_second_n,
    interrupt_request_first_n, dma_read_request_n, dma_write_request_n};
  wire logic [3:0] side_oe = {interrupt_request_second_oe,
    interrupt_request_first_oe, dma_read_request_oe, dma_write_request_oe};
  host_cpu_bus_slave_port dut (.*);
  host_model host (.*);
  // The bench clock runs at the rated 25 ns host clock period; timing is relative.
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (core_write) wdat <= core_write_data;
    if (core_write || core_read) {wadr, wknd} <= {core_address, core_kind};
  end
  task automatic t_xfer();
    logic [31:0] d;
    logic [31:0] w;
    for (int i = 0; i < 3; i++) begin
      w = 32'ha5c3_0f10 + i;
      d = w;
      host.xfer(1'b1, i[1:0] & 2'h1, 22'h3f_fff0 + i[21:0], d);
      `CHK(host.waits, 1)
      `CHK(wdat, w)
      `CHK(wadr, 22'h3f_fff0 + i[21:0])
      `CHK(wknd, i[1:0] & 2'h1)
      @(posedge mclk) core_read_data <= {w[15:0], w[31:16]};
      host.xfer(1'b0, i[1:0] & 2'h2, 22'h00_0001 + i[21:0], d);
      `CHK(host.waits, 1)
      `CHK(d, {w[15:0], w[31:16]})
      `CHK(wadr, 22'h00_0001 + i[21:0])
      `CHK(wknd, i[1:0] & 2'h2)
    end
  endtask
  task automatic t_slow();
    logic [31:0] d;
    @(posedge mclk);
    core_ready <= 1'b0;
    core_read_data <= 32'h1234_5678;
    fork
      host.xfer(1'b0, 2'h0, 22'h00_0002, d);
      begin repeat (6) @(posedge mclk); core_ready <= 1'b1; end
    join
    `CHK(d, 32'h1234_5678)
    `CHK(host.waits, 5)
  endtask
  task automatic t_side();
    for (int v = 0; v < 16; v += 5) begin
      @(posedge mclk) {core_irq_second, core_irq_first, core_dma_read_req,
        core_dma_write_req} <= v[3:0];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      `CHK(side_n, ~v[3:0])
      `CHK(side_oe, 4'hf)
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    `CHK({host_data_oe, transfer_ack_oe, side_oe}, 6'h00)
    rst <= 1'b0;
    t_xfer();
    t_slow();
    t_side();
    stop_test();
  end
  initial begin #50000; bad_count++; stop_test(); end
endmodule
`default_nettype wire
